// >>> verilog/gage_cmd_pkg.sv
// shared constants and carrier types for the sensor command decoder
package gage_cmd_pkg;
    // opcode bases (channel or group number is added)
    localparam logic [7:0] OP_READ_CHAN   = 8'h00; // 0..15
    localparam logic [7:0] OP_JUNC_TEMP   = 8'h40; // 64 + group
    localparam logic [7:0] OP_GROUP_LO    = 8'h58; // 88
    localparam logic [7:0] OP_GROUP_HI    = 8'h59; // 89
    localparam logic [7:0] OP_TARE        = 8'h70; // 112 + chan
    localparam logic [7:0] OP_CAL_READ    = 8'h80; // 128 + chan
    localparam logic [7:0] OP_ZERO        = 8'hb0; // 176 + chan
    localparam logic [7:0] OP_SPAN        = 8'hd0; // 208 + chan
    localparam logic [7:0] OP_CHAN_MASK   = 8'hf0; // base part of a channel opcode
    localparam logic [7:0] OP_GROUP_MASK  = 8'hfe; // base part of a group opcode
    // response lengths in bytes
    localparam logic [4:0] LEN_WORD       = 5'h02;
    localparam logic [4:0] LEN_GROUP      = 5'h10;
    localparam logic [4:0] LEN_CAL        = 5'h06;
    localparam int         CAL_BYTES      = 6;
    // reset values of calibration state
    localparam logic [15:0] RST_OFFSET    = 16'h0000;
    localparam logic [15:0] RST_SPAN      = 16'h0000;

    // one byte on the host byte port
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_s;

    // per-channel gage calibration, read back by the host with OP_CAL_READ
    typedef struct packed {
        logic [15:0] zero_ref;
        logic [15:0] span_load;
        logic [15:0] tare_offset;
    } gage_cal_s;
endpackage : gage_cmd_pkg

// >>> verilog/gage_channel_cal.sv
// calibration store for one gage channel
`timescale 1ns/1ps
module gage_channel_cal (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // strobes from the decoder
    input  wire logic                    zero_stb,
    input  wire logic                    span_stb,
    input  wire logic                    tare_stb,
    input  wire logic [15:0]             span_value,
    // live channel input
    input  wire logic [15:0]             live_value,
    // stored state
    output gage_cmd_pkg::gage_cal_s      cal
);
    gage_cmd_pkg::gage_cal_s next_cal; // next calibration state

    // capture live input or host load on each strobe
    always_comb begin
        next_cal = cal;
        if (zero_stb) begin
            next_cal.zero_ref = live_value;
        end
        if (span_stb) begin
            next_cal.span_load = span_value;
        end
        if (tare_stb) begin
            next_cal.tare_offset = live_value;
        end
    end

    // register, frozen while clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cal <= '{gage_cmd_pkg::RST_OFFSET, gage_cmd_pkg::RST_SPAN,
                     gage_cmd_pkg::RST_OFFSET};
        end else if (clk_en) begin
            cal <= next_cal;
        end
    end
endmodule : gage_channel_cal

// >>> verilog/gage_cmd_decoder.sv
// command decoder for the sensor readout byte port
`timescale 1ns/1ps
module gage_cmd_decoder #(
    parameter int NUM_CHAN = 16 // 8 or 16 channel model
) (
    // clock, reset, enable
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // command bytes from host
    input  gage_cmd_pkg::byte_s         cmd_in,
    output logic                        cmd_ready,
    // response bytes to host
    output gage_cmd_pkg::byte_s         rsp_out,
    input  wire logic                   rsp_ack,
    // acquisition side
    input  wire logic [NUM_CHAN*16-1:0] chan_values,
    input  wire logic [31:0]            junction_temps,
    output gage_cmd_pkg::gage_cal_s     cal_view
);
    typedef enum {IDLE, GET_SPAN_MSB, GET_SPAN_LSB, GET_TYPE, SEND} state_e;

    state_e      state;          // decoder state
    state_e      next_state;
    logic [3:0]  chan;           // addressed channel
    logic [3:0]  next_chan;
    logic        group;          // addressed group
    logic        next_group;
    logic [4:0]  remain;         // response bytes left
    logic [4:0]  next_remain;
    logic [4:0]  index;          // response byte index
    logic [4:0]  next_index;
    logic [7:0]  span_msb;       // held span high byte
    logic [7:0]  next_span_msb;
    logic [7:0]  type_code;      // sensor_type_code byte, accepted only
    logic [7:0]  next_type_code;
    logic [1:0]  kind;           // 0 chan,1 group,2 temp,3 cal
    logic [1:0]  next_kind;
    logic [7:0]  rsp_data;       // registered response byte
    logic [7:0]  next_rsp_data;
    logic [NUM_CHAN-1:0] zero_stb, span_stb, tare_stb;
    logic [15:0] span_word;
    gage_cmd_pkg::gage_cal_s cal_all [NUM_CHAN];
    logic [7:0]  op;
    logic        take;

    assign op        = cmd_in.data;
    assign cmd_ready = (state != SEND);
    assign take      = cmd_in.valid && cmd_ready;
    assign span_word = {span_msb, op};
    assign rsp_out   = '{(state == SEND), rsp_data};
    assign cal_view  = cal_all[chan];

    // one calibration store per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_cal
            gage_channel_cal u_cal (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .clk_en     (clk_en),
                .zero_stb   (zero_stb[g]),
                .span_stb   (span_stb[g]),
                .tare_stb   (tare_stb[g]),
                .span_value (span_word),
                .live_value (chan_values[g*16 +: 16]),
                .cal        (cal_all[g])
            );
        end
    endgenerate

    // byte selected for a given response index
    function automatic logic [7:0] pick(input logic [1:0] k, input logic [3:0] c,
                                        input logic gr, input logic [4:0] i);
        logic [3:0]  ch;
        logic [15:0] w;
        logic [47:0] cw;
        ch = c;
        if (k == 2'd1) begin
            ch = {gr, i[3:1]};
        end
        w = chan_values[ch*16 +: 16];
        if (k == 2'd2) begin
            w = junction_temps[gr*16 +: 16];
        end
        cw = cal_all[c];
        if (k == 2'd3) begin
            pick = cw[47 - i*8 -: 8];
        end else begin
            pick = i[0] ? w[7:0] : w[15:8];          // msb first
        end
    endfunction : pick

    // command decode and response sequencing
    always_comb begin
        next_state     = state;
        next_chan      = chan;
        next_group     = group;
        next_remain    = remain;
        next_index     = index;
        next_span_msb  = span_msb;
        next_type_code = type_code;
        next_kind      = kind;
        next_rsp_data  = rsp_data;
        zero_stb       = '0;
        span_stb       = '0;
        tare_stb       = '0;
        case (state)
            IDLE: begin
                if (take) begin
                    next_chan  = op[3:0];
                    next_group = op[0];
                    next_index = 5'h00;
                    if ((op & gage_cmd_pkg::OP_CHAN_MASK) == gage_cmd_pkg::OP_READ_CHAN
                        && op[3:0] < NUM_CHAN) begin
                        next_kind   = 2'd0;
                        next_remain = gage_cmd_pkg::LEN_WORD;
                        next_state  = SEND;
                        next_rsp_data = pick(2'd0, op[3:0], 1'b0, 5'h00);
                    end else if ((op == gage_cmd_pkg::OP_GROUP_LO) ||
                                 (op == gage_cmd_pkg::OP_GROUP_HI && NUM_CHAN > 8)) begin
                        next_kind   = 2'd1;
                        next_remain = gage_cmd_pkg::LEN_GROUP;
                        next_state  = SEND;
                        next_rsp_data = pick(2'd1, 4'h0, op[0], 5'h00);
                    end else if ((op & gage_cmd_pkg::OP_GROUP_MASK) == gage_cmd_pkg::OP_JUNC_TEMP
                                 && (!op[0] || NUM_CHAN > 8)) begin
                        next_kind   = 2'd2;
                        next_remain = gage_cmd_pkg::LEN_WORD;
                        next_state  = SEND;
                        next_rsp_data = pick(2'd2, 4'h0, op[0], 5'h00);
                    end else if (op[3:0] < NUM_CHAN) begin
                        // gage commands, channel in low nibble
                        case (op & gage_cmd_pkg::OP_CHAN_MASK)
                            gage_cmd_pkg::OP_TARE: tare_stb[op[3:0]] = 1'b1;
                            gage_cmd_pkg::OP_ZERO: zero_stb[op[3:0]] = 1'b1;
                            gage_cmd_pkg::OP_SPAN: next_state = GET_SPAN_MSB;
                            gage_cmd_pkg::OP_CAL_READ: next_state = GET_TYPE;
                            default: next_state = IDLE;  // unknown opcode ignored
                        endcase
                    end
                end
            end
            GET_SPAN_MSB: begin
                if (take) begin
                    next_span_msb = op;
                    next_state    = GET_SPAN_LSB;
                end
            end
            GET_SPAN_LSB: begin
                if (take) begin
                    span_stb[chan] = 1'b1;
                    next_state     = IDLE;
                end
            end
            GET_TYPE: begin
                if (take) begin
                    next_type_code = op;
                    next_kind      = 2'd3;
                    next_remain    = gage_cmd_pkg::LEN_CAL;
                    next_state     = SEND;
                    next_rsp_data  = pick(2'd3, chan, 1'b0, 5'h00);
                end
            end
            SEND: begin
                // hold each byte until the host takes it
                if (rsp_ack) begin
                    next_index  = index + 5'h01;
                    next_remain = remain - 5'h01;
                    if (remain == 5'h01) begin
                        next_state = IDLE;
                    end else begin
                        // bytes remain, so fetch the byte at the next index; after the last one rsp_data keeps its value
                        next_rsp_data = pick(kind, chan, group, index + 5'h01);
                    end
                end
            end
            default: next_state = IDLE;
        endcase
    end

    // register decoder state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state     <= IDLE;
            chan      <= 4'h0;
            group     <= 1'b0;
            remain    <= 5'h00;
            index     <= 5'h00;
            span_msb  <= 8'h00;
            type_code <= 8'h00;
            kind      <= 2'd0;
            rsp_data  <= 8'h00;
        end else if (clk_en) begin
            state     <= next_state;
            chan      <= next_chan;
            group     <= next_group;
            remain    <= next_remain;
            index     <= next_index;
            span_msb  <= next_span_msb;
            type_code <= next_type_code;
            kind      <= next_kind;
            rsp_data  <= next_rsp_data;
        end
    end
endmodule : gage_cmd_decoder

// >>> tb/gage_cmd_decoder_sva.sv
// port-level assertion checker for the sensor command decoder
`timescale 1ns/1ps
module gage_cmd_decoder_sva #(
    parameter int NUM_CHAN = 16 // channel count of the checked model
) (
    // clock, reset, enable
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // byte port
    input  gage_cmd_pkg::byte_s         cmd_in,
    input  wire logic                   cmd_ready,
    input  gage_cmd_pkg::byte_s         rsp_out,
    input  wire logic                   rsp_ack,
    // acquisition side
    input  wire logic [NUM_CHAN*16-1:0] chan_values,
    input  wire logic [31:0]            junction_temps,
    input  gage_cmd_pkg::gage_cal_s     cal_view
);
    logic [5:0] arg_st;      // {argument bytes left, opcode high nibble}
    logic [5:0] next_arg_st; // next argument state
    logic       take;        // byte accepted on this edge
    logic       op_take;     // accepted byte is an opcode
    logic [7:0] sel_msb;     // msb of the channel named by the byte
    logic [7:0] temp_msb;    // msb of the group named by the byte
    assign take     = cmd_in.valid && cmd_ready && clk_en;
    assign op_take  = take && arg_st[5:4] == 2'h0;
    assign sel_msb  = chan_values[cmd_in.data[3:0]*16+8 +: 8];
    assign temp_msb = cmd_in.data[0] ? junction_temps[31:24] : junction_temps[15:8];
    // argument tracking, so data bytes are never taken for opcodes
    always_comb begin
        next_arg_st = arg_st;
        if (take && arg_st[5:4] != 2'h0) begin
            next_arg_st[5:4] = arg_st[5:4] - 2'h1;
        end else if (take) begin
            next_arg_st[3:0] = cmd_in.data[7:4];
            next_arg_st[5:4] = (cmd_in.data[7:4] == 4'hd) ? 2'h2
                             : {1'b0, cmd_in.data[7:4] == 4'h8};
        end
    end
    // register only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arg_st <= 6'h00;
        end else begin
            arg_st <= next_arg_st;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_BUSY_NO_CMD: assert property (rsp_out.valid |-> !cmd_ready)
        else $error("command port open while response pending");
    AST_CHAN_MSB: assert property (op_take && cmd_in.data[7:4] == 4'h0 |=>
        rsp_out.valid && rsp_out.data == $past(sel_msb)) else $error("channel msb wrong");
    AST_TEMP_MSB: assert property (op_take && cmd_in.data[7:1] == 7'h20 |=>
        rsp_out.valid && rsp_out.data == $past(temp_msb)) else $error("temperature msb wrong");
    AST_GROUP_FIRST: assert property (op_take && cmd_in.data == 8'h58 |=>
        rsp_out.valid && rsp_out.data == $past(chan_values[15:8]))
        else $error("group first byte wrong");
    AST_NO_REPLY: assert property (
        op_take && cmd_in.data[7:4] inside {4'h7, 4'hb, 4'hd}
        |=> !rsp_out.valid && cmd_ready) else $error("calibration command answered");
    AST_CAL_REPLY: assert property (take && arg_st == 6'h18 |=>
        rsp_out.valid && !cmd_ready) else $error("calibration readback missing");
    AST_HOLD_BYTE: assert property (rsp_out.valid && !(rsp_ack && clk_en) |=>
        rsp_out.valid && $stable(rsp_out.data)) else $error("response byte dropped early");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> cmd_ready && !rsp_out.valid)
        else $error("port busy after reset");
    COV_GROUP: cover property (op_take && cmd_in.data[7:1] == 7'h2c);
    COV_CAL: cover property (take && arg_st == 6'h18);
    COV_FREEZE: cover property (rsp_out.valid && !clk_en);
endmodule : gage_cmd_decoder_sva

bind gage_cmd_decoder gage_cmd_decoder_sva #(.NUM_CHAN(NUM_CHAN)) i_gage_cmd_decoder_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cmd_in(cmd_in),
    .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_ack(rsp_ack), .chan_values(chan_values),
    .junction_temps(junction_temps), .cal_view(cal_view));

// >>> tb/host_port_model.sv
// host computer model: sends command bytes and collects response bytes
`timescale 1ns/1ps
module host_port_model (
    // clock
    input  wire logic           clk_sys,
    // command side
    output gage_cmd_pkg::byte_s cmd_in,
    input  wire logic           cmd_ready,
    // response side
    input  gage_cmd_pkg::byte_s rsp_out,
    output logic                rsp_ack
);
    initial begin
        cmd_in  = '0;
        rsp_ack = 1'b0;
    end
    // hold a byte until ready; the byte is driven at once, even while a response is pending
    task automatic send(input logic [7:0] b, output bit ok);
        int n;
        n = 0;
        @(negedge clk_sys);
        cmd_in = '{valid: 1'b1, data: b};
        while (!cmd_ready && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        ok = (n < 100);
        @(negedge clk_sys);
        cmd_in = '{valid: 1'b0, data: ~b}; // released line shows no stale byte
    endtask : send
    // take one response byte with a single-cycle acknowledge
    task automatic recv(output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (!rsp_out.valid && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        ok = (n < 100);
        b = rsp_out.data; // stored unchanged
        rsp_ack = ok;
        @(negedge clk_sys);
        rsp_ack = 1'b0;
    endtask : recv
endmodule : host_port_model

// >>> tb/sensor_readout_gage_commands_tb.sv
// self-checking bench for the sensor command decoder
`timescale 1ns/1ps
module sensor_readout_gage_commands_tb;
    logic                    clk_sys        = 1'b0; // 40 MHz clock
    logic                    rst_n          = 1'b0; // active-low reset
    logic                    clk_en         = 1'b1; // pauses decoder
    gage_cmd_pkg::byte_s     cmd_in;                // from host model
    logic                    cmd_ready;
    gage_cmd_pkg::byte_s     rsp_out;
    logic                    rsp_ack;
    logic [255:0]            chan_values    = '0;   // live channel words
    logic [31:0]             junction_temps = '0;
    gage_cmd_pkg::gage_cal_s cal_view;
    int                      miscompares    = 0;
    int                      total_checks   = 0;
    int                      chv[16];               // reference live values
    int                      jt[2];                 // reference temperatures
    int                      exp_q[$];              // expected words, oldest first
    always #12.5 clk_sys = ~clk_sys;
    gage_cmd_decoder #(.NUM_CHAN(16)) i_gage_cmd_decoder (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cmd_in(cmd_in),
        .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_ack(rsp_ack),
        .chan_values(chan_values), .junction_temps(junction_temps), .cal_view(cal_view));
    host_port_model i_host_port_model (
        .clk_sys(clk_sys), .cmd_in(cmd_in), .cmd_ready(cmd_ready),
        .rsp_out(rsp_out), .rsp_ack(rsp_ack));
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one command byte; a stuck port ends the run
    task automatic tx(input logic [7:0] b);
        bit ok;
        i_host_port_model.send(b, ok);
        if (!ok) begin
            miscompares++;
            test_done();
        end
    endtask : tx
    // one word, msb first, compared with the reference
    task automatic rx_word(input logic [15:0] exp);
        logic [7:0] hi;
        logic [7:0] lo;
        bit         ok1;
        bit         ok2;
        i_host_port_model.recv(hi, ok1);
        i_host_port_model.recv(lo, ok2);
        if (!(ok1 && ok2)) begin
            miscompares++;
            test_done();
        end
        check({hi, lo}, exp);
    endtask : rx_word
    // new live values; idle first so pending captures see the old ones
    task automatic new_data();
        repeat (4) @(negedge clk_sys);
        for (int c = 0; c < 16; c++) begin
            chv[c] = $urandom & 32'hffff;
            chan_values[c*16 +: 16] = chv[c][15:0];
        end
        jt[0] = $urandom & 32'hffff;
        jt[1] = $urandom & 32'hffff;
        junction_temps = {jt[1][15:0], jt[0][15:0]};
    endtask : new_data
    initial begin
        int          ch;
        logic [15:0] zr;
        logic [15:0] sp;
        logic [15:0] tr;
        logic [7:0]  ty;
        void'($urandom(57122));
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        new_data();
        // every channel singly
        for (int c = 0; c < 16; c++) begin
            tx(c[7:0]);
            rx_word(chv[c][15:0]);
        end
        // both groups, decoder paused while the first byte stands
        for (int g = 0; g < 2; g++) begin
            tx(8'h58 + g[7:0]);
            @(negedge clk_sys);
            clk_en = 1'b0;
            repeat (3) @(negedge clk_sys);
            clk_en = 1'b1;
            for (int c = 0; c < 8; c++) begin
                rx_word(chv[g*8+c][15:0]);
            end
        end
        // junction temperature per group; the bench stands in for a fitted
        // termination board, so the word is meaningful here
        for (int g = 0; g < 2; g++) begin
            tx(8'h40 + g[7:0]);
            rx_word(jt[g][15:0]);
        end
        // zero, span, tare, then readback; edge channels first
        for (int k = 0; k < 4; k++) begin
            ch = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(14, 1);
            tx(8'hb0 + ch[7:0]);
            zr = chv[ch][15:0];
            new_data();
            sp = 16'($urandom);
            tx(8'hd0 + ch[7:0]);
            tx(sp[15:8]);
            tx(sp[7:0]);
            new_data();
            tx(8'h70 + ch[7:0]);
            tr = chv[ch][15:0];
            new_data();
            ty = 8'($urandom);
            // model of the stored words, in readback order
            exp_q.push_back(int'(zr));
            exp_q.push_back(int'(sp));
            exp_q.push_back(int'(tr));
            tx(8'h80 + ch[7:0]);
            tx(ty);
            rx_word(16'(exp_q.pop_front()));
            rx_word(16'(exp_q.pop_front()));
            rx_word(16'(exp_q.pop_front()));
            check(cal_view.zero_ref, zr);
            check(cal_view.span_load, sp);
            check(cal_view.tare_offset, tr);
        end
        test_done();
    end
endmodule : sensor_readout_gage_commands_tb
